// *** brd_params.svh ***
`ifndef BRD_PARAMS_SVH
`define BRD_PARAMS_SVH

// ----------------------------------------------------------------------
// Instruction word layout.
// ----------------------------------------------------------------------
`define BRD_IW_WIDTH 14
`define BRD_OP6_MSB 13
`define BRD_OP6_LSB 8
`define BRD_D_BIT 7
`define BRD_F_MSB 6
`define BRD_B_MSB 9
`define BRD_B_LSB 7

// ----------------------------------------------------------------------
// Timing: oscillator clocks per instruction cycle.
// ----------------------------------------------------------------------
`define BRD_OSC_PER_CYC 4
`define BRD_PH_FETCH 2'h0
`define BRD_PH_READ 2'h1
`define BRD_PH_MODIFY 2'h2
`define BRD_PH_WRITE 2'h3

// ----------------------------------------------------------------------
// Opcode patterns.
// ----------------------------------------------------------------------
`define BRD_OP_ADD 6'h07
`define BRD_OP_ADDC 6'h3D
`define BRD_OP_AND 6'h05
`define BRD_OP_IOR 6'h04
`define BRD_OP_COM 6'h09
`define BRD_OP_DECSZ 6'h0B
`define BRD_OP_INCSZ 6'h0F
`define BRD_OP_RETLIT 6'h34
`define BRD_OP_SHL 6'h35
`define BRD_OP_SHRL 6'h36
`define BRD_OP_SHRA 6'h37
`define BRD_OP4_BITCLR 4'h6
`define BRD_OP4_BITSET 4'h7
`define BRD_OP5_RELJ 5'h19
`define BRD_OP3_CALL 3'h4
`define BRD_OP3_JUMP 3'h5
`define BRD_IW_RETURN 14'h0008
`define BRD_IW_INTEXIT 14'h0009
`define BRD_IW_CALLACC 14'h000A
`define BRD_IW_RELACC 14'h000B

// ----------------------------------------------------------------------
// Reset values and indirect alias addresses.
// ----------------------------------------------------------------------
`define BRD_RST_IW 14'h0000
`define BRD_RST_BYTE 8'h00
`define BRD_IND_ADDR0 7'h00
`define BRD_IND_ADDR1 7'h01

`endif

// *** brd_pkg.sv ***
package brd_pkg;

  // ----------------------------------------------------------------------
  // Instruction cycle kinds.
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    BRD_ST_EXEC  = 3'h1,
    BRD_ST_EXTRA = 3'h2,
    BRD_ST_NOP   = 3'h4
  } brd_state_e;

  // ----------------------------------------------------------------------
  // Datapath operations carried out here.
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    BRD_ALU_NONE = 4'h0,
    BRD_ALU_ADD  = 4'h1,
    BRD_ALU_ADDC = 4'h2,
    BRD_ALU_AND  = 4'h3,
    BRD_ALU_IOR  = 4'h4,
    BRD_ALU_COM  = 4'h5,
    BRD_ALU_DEC  = 4'h6,
    BRD_ALU_INC  = 4'h7,
    BRD_ALU_BTC  = 4'h8,
    BRD_ALU_BTS  = 4'h9
  } brd_alu_e;

endpackage : brd_pkg

// *** brd_decode.sv ***
`timescale 1ns/1ps
`include "brd_params.svh"
module brd_decode
  import brd_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Program memory word
  input wire logic [13:0] instr_i,
  output logic fetch_o,
  // Pointer state: high when pointer n addresses program memory
  input wire logic [1:0] ptr_pm_i,
  // File register port
  input wire logic [7:0] reg_rdata_i,
  output logic [6:0] reg_addr_o,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  output logic indirect_o,
  output logic ptr_sel_o,
  // Core state
  output logic [7:0] acc_o,
  output logic carry_o,
  output logic dcarry_o,
  output logic zero_o,
  // Cycle status
  output logic [1:0] phase_o,
  output logic extra_cycle_o,
  output logic nop_cycle_o,
  output logic flow_change_o
);

  // ----------------------------------------------------------------------
  // Decode functions.
  // ----------------------------------------------------------------------

  // Words that name a file register; the low control region does not.
  function automatic logic fn_uses_file(input logic [13:0] iw);
    logic r;
    r = 1'b0;
    case (iw[13:12])
      2'b00: r = (iw[11:7] != 5'h00) || (iw[11:8] == 4'h0 && iw[7]);
      2'b01: r = 1'b1;
      2'b11: r = (iw[13:8] == `BRD_OP_ADDC) || (iw[13:8] == `BRD_OP_SHL) ||
                 (iw[13:8] == `BRD_OP_SHRL) || (iw[13:8] == `BRD_OP_SHRA);
      default: r = 1'b0;
    endcase
    return r;
  endfunction : fn_uses_file

  // Indirect alias is the file address 0 or 1.
  function automatic logic fn_is_ind(input logic [13:0] iw);
    logic [6:0] fa;
    fa = iw[`BRD_F_MSB:0];
    return fn_uses_file(iw) &&
           (fa == `BRD_IND_ADDR0 || fa == `BRD_IND_ADDR1);
  endfunction : fn_is_ind

  // Flow changes that always cost a second cycle.
  function automatic logic fn_always_two(input logic [13:0] iw);
    logic r;
    r = (iw[13:11] == `BRD_OP3_CALL);
    r = r || (iw[13:11] == `BRD_OP3_JUMP);
    r = r || (iw[13:9] == `BRD_OP5_RELJ);
    r = r || (iw == `BRD_IW_RELACC);
    r = r || (iw == `BRD_IW_CALLACC);
    r = r || (iw == `BRD_IW_RETURN) || (iw == `BRD_IW_INTEXIT);
    r = r || (iw[13:8] == `BRD_OP_RETLIT);
    return r;
  endfunction : fn_always_two

  // Map an opcode to the operation this block performs.
  function automatic brd_alu_e fn_alu(input logic [13:0] iw);
    brd_alu_e r;
    r = BRD_ALU_NONE;
    case (iw[13:8])
      `BRD_OP_ADD: r = BRD_ALU_ADD;
      `BRD_OP_ADDC: r = BRD_ALU_ADDC;
      `BRD_OP_AND: r = BRD_ALU_AND;
      `BRD_OP_IOR: r = BRD_ALU_IOR;
      `BRD_OP_COM: r = BRD_ALU_COM;
      `BRD_OP_DECSZ: r = BRD_ALU_DEC;
      `BRD_OP_INCSZ: r = BRD_ALU_INC;
      default: r = BRD_ALU_NONE;
    endcase
    // Bit-test skips carry the bit number in [9:7].
    if (iw[13:10] == `BRD_OP4_BITCLR) begin
      r = BRD_ALU_BTC;
    end else if (iw[13:10] == `BRD_OP4_BITSET) begin
      r = BRD_ALU_BTS;
    end
    return r;
  endfunction : fn_alu

  // ----------------------------------------------------------------------
  // Sequencing state.
  // ----------------------------------------------------------------------
  brd_state_e state_ff, nxt_state;
  logic [1:0] phase_ff, nxt_phase;
  logic [13:0] iw_ff, nxt_iw;
  logic slow_ff, nxt_slow;
  logic flow_ff, nxt_flow;

  // ----------------------------------------------------------------------
  // Datapath state.
  // ----------------------------------------------------------------------
  logic [7:0] rdata_ff, nxt_rdata;
  logic [7:0] res_ff, nxt_res;
  logic [7:0] acc_ff, nxt_acc;
  logic c_ff, nxt_c;
  logic dc_ff, nxt_dc;
  logic z_ff, nxt_z;
  logic rc_ff, nxt_rc;
  logic rdc_ff, nxt_rdc;
  logic taken_ff, nxt_taken;

  // ----------------------------------------------------------------------
  // Decoded fields of the held word.
  // ----------------------------------------------------------------------
  brd_alu_e alu_op;
  logic act;
  logic dest_reg;
  logic [2:0] bit_idx;
  logic writes_res;
  logic sets_czdc;
  logic sets_z;

  // The word is decoded as a whole; unlisted bits never steer it.
  assign alu_op = fn_alu(iw_ff);
  assign dest_reg = iw_ff[`BRD_D_BIT];
  assign bit_idx = iw_ff[`BRD_B_MSB:`BRD_B_LSB];
  assign sets_czdc = (alu_op == BRD_ALU_ADD) || (alu_op == BRD_ALU_ADDC);
  assign sets_z = sets_czdc || (alu_op == BRD_ALU_AND) ||
                  (alu_op == BRD_ALU_IOR) || (alu_op == BRD_ALU_COM);
  assign writes_res = sets_z || (alu_op == BRD_ALU_DEC) ||
                      (alu_op == BRD_ALU_INC);
  // A slow indirect access moves the whole access into the extra cycle.
  assign act = (state_ff == BRD_ST_EXEC && !slow_ff) ||
               (state_ff == BRD_ST_EXTRA);

  // ----------------------------------------------------------------------
  // Sequencer: four phases per cycle and the cycle kind.
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_phase = phase_ff + 2'h1;
    nxt_state = state_ff;
    nxt_iw = iw_ff;
    nxt_slow = slow_ff;
    nxt_flow = 1'b0;
    if (phase_ff == `BRD_PH_FETCH && state_ff == BRD_ST_EXEC) begin
      nxt_iw = instr_i;
      nxt_slow = fn_is_ind(instr_i) && ptr_pm_i[instr_i[0]];
    end
    if (phase_ff == `BRD_PH_WRITE) begin
      case (state_ff)
        BRD_ST_EXEC: begin
          if (slow_ff) begin
            nxt_state = BRD_ST_EXTRA;
          end else if (fn_always_two(iw_ff) || taken_ff) begin
            nxt_state = BRD_ST_NOP;
            nxt_flow = 1'b1;
          end else begin
            nxt_state = BRD_ST_EXEC;
          end
        end
        BRD_ST_EXTRA: begin
          if (fn_always_two(iw_ff) || taken_ff) begin
            nxt_state = BRD_ST_NOP;
            nxt_flow = 1'b1;
          end else begin
            nxt_state = BRD_ST_EXEC;
          end
        end
        BRD_ST_NOP: nxt_state = BRD_ST_EXEC;
        default: nxt_state = BRD_ST_EXEC;
      endcase
    end
  end

  // Registers of the sequencer.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= BRD_ST_EXEC;
      phase_ff <= `BRD_PH_FETCH;
      iw_ff <= `BRD_RST_IW;
      slow_ff <= 1'b0;
      flow_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
      iw_ff <= nxt_iw;
      slow_ff <= nxt_slow;
      flow_ff <= nxt_flow;
    end
  end

  // ----------------------------------------------------------------------
  // Datapath: read in phase 1, modify in phase 2, store in phase 3.
  // ----------------------------------------------------------------------
  always_comb begin
    logic [8:0] sum;
    logic [4:0] lsum;
    logic cin;
    sum = 9'h000;
    lsum = 5'h00;
    cin = (alu_op == BRD_ALU_ADDC) ? c_ff : 1'b0;
    nxt_rdata = rdata_ff;
    nxt_res = res_ff;
    nxt_acc = acc_ff;
    nxt_c = c_ff;
    nxt_dc = dc_ff;
    nxt_z = z_ff;
    nxt_rc = rc_ff;
    nxt_rdc = rdc_ff;
    nxt_taken = taken_ff;
    // Each instruction starts with no skip pending.
    if (phase_ff == `BRD_PH_FETCH && state_ff == BRD_ST_EXEC) begin
      nxt_taken = 1'b0;
    end
    // The register is read even by operations that only overwrite it.
    if (act && phase_ff == `BRD_PH_READ && fn_uses_file(iw_ff)) begin
      nxt_rdata = reg_rdata_i;
    end
    if (act && phase_ff == `BRD_PH_MODIFY) begin
      sum = {1'b0, acc_ff} + {1'b0, rdata_ff} + {8'h00, cin};
      lsum = {1'b0, acc_ff[3:0]} + {1'b0, rdata_ff[3:0]} + {4'h0, cin};
      nxt_rc = sum[8];
      nxt_rdc = lsum[4];
      case (alu_op)
        BRD_ALU_ADD, BRD_ALU_ADDC: nxt_res = sum[7:0];
        BRD_ALU_AND: nxt_res = acc_ff & rdata_ff;
        BRD_ALU_IOR: nxt_res = acc_ff | rdata_ff;
        BRD_ALU_COM: nxt_res = ~rdata_ff;
        BRD_ALU_DEC: nxt_res = rdata_ff - 8'h01;
        BRD_ALU_INC: nxt_res = rdata_ff + 8'h01;
        default: nxt_res = rdata_ff;
      endcase
      case (alu_op)
        BRD_ALU_DEC: nxt_taken = (rdata_ff == 8'h01);
        BRD_ALU_INC: nxt_taken = (rdata_ff == 8'hFF);
        BRD_ALU_BTC: nxt_taken = !rdata_ff[bit_idx];
        BRD_ALU_BTS: nxt_taken = rdata_ff[bit_idx];
        default: nxt_taken = 1'b0;
      endcase
    end
    // Store the result and the flags at the close of the cycle.
    if (act && phase_ff == `BRD_PH_WRITE) begin
      if (writes_res && !dest_reg) begin
        nxt_acc = res_ff;
      end
      if (sets_czdc) begin
        nxt_c = rc_ff;
        nxt_dc = rdc_ff;
      end
      if (sets_z) begin
        nxt_z = (res_ff == 8'h00);
      end
    end
  end

  // Registers of the datapath.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= `BRD_RST_BYTE;
      res_ff <= `BRD_RST_BYTE;
      acc_ff <= `BRD_RST_BYTE;
      c_ff <= 1'b0;
      dc_ff <= 1'b0;
      z_ff <= 1'b0;
      rc_ff <= 1'b0;
      rdc_ff <= 1'b0;
      taken_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      res_ff <= nxt_res;
      acc_ff <= nxt_acc;
      c_ff <= nxt_c;
      dc_ff <= nxt_dc;
      z_ff <= nxt_z;
      rc_ff <= nxt_rc;
      rdc_ff <= nxt_rdc;
      taken_ff <= nxt_taken;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------

  // Address and pointer choice come straight from the held word.
  assign reg_addr_o = iw_ff[`BRD_F_MSB:0];
  assign indirect_o = fn_is_ind(iw_ff);
  assign ptr_sel_o = iw_ff[0];
  assign reg_wdata_o = res_ff;
  // Strobes are combinational; the word stays stable from phase 1 until the next fetch phase ends.
  assign reg_rd_o = act && phase_ff == `BRD_PH_READ &&
                    fn_uses_file(iw_ff);
  assign reg_wr_o = act && phase_ff == `BRD_PH_WRITE && writes_res &&
                    dest_reg;
  // Next word wanted once the last cycle of this one is closing.
  assign fetch_o = phase_ff == `BRD_PH_WRITE && nxt_state == BRD_ST_EXEC;
  assign acc_o = acc_ff;
  assign carry_o = c_ff;
  assign dcarry_o = dc_ff;
  assign zero_o = z_ff;
  assign phase_o = phase_ff;
  assign extra_cycle_o = (state_ff == BRD_ST_EXTRA);
  // The no-op cycle only requests the next fetch: no file strobes, no flag changes.
  assign nop_cycle_o = (state_ff == BRD_ST_NOP);
  assign flow_change_o = flow_ff;

endmodule : brd_decode

// *** brd_decode_chk.sv ***
`timescale 1ns/1ps
module brd_decode_chk (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Watched outputs
  input wire logic fetch_o,
  input wire logic [6:0] reg_addr_o,
  input wire logic reg_rd_o,
  input wire logic reg_wr_o,
  input wire logic [7:0] acc_o,
  input wire logic [1:0] phase_o,
  input wire logic extra_cycle_o,
  input wire logic nop_cycle_o,
  input wire logic flow_change_o
);
  // All checks sample on the core clock and sleep during reset.
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  phase_step_a: assert property (1'b1 |=>
    phase_o == $past(phase_o) + 2'h1)
    else $error("phase did not advance by one");
  rd_phase_a: assert property (reg_rd_o |-> phase_o == 2'h1)
    else $error("read strobe outside phase one");
  wr_after_rd_a: assert property (reg_wr_o |->
    phase_o == 2'h3 && $past(reg_rd_o, 2))
    else $error("write strobe without earlier read");
  fetch_end_a: assert property (fetch_o |->
    phase_o == 2'h3 ##1 !fetch_o [*3])
    else $error("fetch outside last phase");
  nop_len_a: assert property ($rose(nop_cycle_o) |->
    nop_cycle_o [*4] ##1 !nop_cycle_o)
    else $error("no-op cycle not four clocks");
  flow_pulse_a: assert property (flow_change_o |->
    nop_cycle_o && phase_o == 2'h0 ##1 !flow_change_o)
    else $error("flow change pulse misplaced");
  quiet_nop_a: assert property (nop_cycle_o |->
    !reg_rd_o && !reg_wr_o && !extra_cycle_o)
    else $error("strobe during no-op cycle");
  extra_len_a: assert property ($rose(extra_cycle_o) |->
    phase_o == 2'h0 && !$past(reg_rd_o, 3) ##1 extra_cycle_o [*3])
    else $error("extra cycle malformed");
  acc_when_a: assert property (acc_o != $past(acc_o) |->
    $past(phase_o) == 2'h3)
    else $error("accumulator changed mid cycle");
  addr_hold_a: assert property (phase_o[1] |->
    $stable(reg_addr_o))
    else $error("file address moved mid cycle");

  // Main scenarios worth seeing at least once.
  skip_c: cover property ($rose(nop_cycle_o));
  extra_c: cover property ($rose(extra_cycle_o));
  write_c: cover property (reg_wr_o);
endmodule : brd_decode_chk

bind brd_decode brd_decode_chk brd_decode_chk_i (.mclk_i, .rst_i, .fetch_o,
  .reg_addr_o, .reg_rd_o, .reg_wr_o, .acc_o, .phase_o, .extra_cycle_o,
  .nop_cycle_o, .flow_change_o);

// *** brd_fregs.sv ***
`timescale 1ns/1ps
module brd_fregs (
  // Clock
  input wire logic mclk_i,
  // File register port
  input wire logic [6:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o
);
  logic [7:0] mem [128];
  logic [7:0] last_ff = 8'h00;

  // Data shows only while read; else the inverse, so late samples fail.
  always_comb begin
    if (reg_rd_i) begin
      reg_rdata_o = mem[reg_addr_i];
    end else begin
      reg_rdata_o = ~last_ff;
    end
  end

  // Stores land on the edge ending the write phase.
  always @(posedge mclk_i) begin
    if (reg_rd_i) begin
      last_ff <= mem[reg_addr_i];
    end
    if (reg_wr_i) begin
      mem[reg_addr_i] <= reg_wdata_i;
    end
  end
endmodule : brd_fregs

// *** testbench.sv ***
`timescale 1ns/1ps
`include "brd_params.svh"
module testbench;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [13:0] instr_i = 14'h0000;
  logic [1:0] ptr_pm_i = 2'h0;
  logic [7:0] reg_rdata_i, reg_wdata_o, acc_o;
  logic [6:0] reg_addr_o;
  logic [1:0] phase_o;
  logic fetch_o, reg_rd_o, reg_wr_o, indirect_o, ptr_sel_o, carry_o;
  logic dcarry_o, zero_o, extra_cycle_o, nop_cycle_o, flow_change_o;
  int err_count = 0;
  int comparisons = 0;
  logic [15:0] lf = 16'hF5C7; // Seed 62919.
  logic [15:0] v;
  logic [13:0] wd;
  logic [7:0] mem_m [128];
  logic [7:0] acc_m;
  logic c_m, dc_m, z_m, ind_s, sel_s;
  logic [13:0] fw [8] = '{14'h2000, 14'h2800, 14'h3200, 14'h3400,
    14'h0008, 14'h0009, 14'h000A, 14'h000B};
  logic [13:0] fm [8] = '{14'h07FF, 14'h07FF, 14'h01FF, 14'h00FF,
    14'h0000, 14'h0000, 14'h0000, 14'h0000};
  logic [5:0] ops [7] = '{`BRD_OP_ADD, `BRD_OP_ADDC, `BRD_OP_AND,
    `BRD_OP_IOR, `BRD_OP_COM, `BRD_OP_DECSZ, `BRD_OP_INCSZ};

  brd_decode brd_decode_i (.mclk_i, .rst_i, .instr_i, .fetch_o, .ptr_pm_i,
    .reg_rdata_i, .reg_addr_o, .reg_rd_o, .reg_wr_o, .reg_wdata_o,
    .indirect_o, .ptr_sel_o, .acc_o, .carry_o, .dcarry_o, .zero_o,
    .phase_o, .extra_cycle_o, .nop_cycle_o, .flow_change_o);
  brd_fregs brd_fregs_i (.mclk_i(mclk_i), .reg_addr_i(reg_addr_o),
    .reg_rd_i(reg_rd_o), .reg_wr_i(reg_wr_o), .reg_wdata_i(reg_wdata_o),
    .reg_rdata_o(reg_rdata_i));

  // Free-running core clock, 10 ns period.
  always #5 mclk_i = ~mclk_i;

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction : rnd

  // Mirrors one word into the expected state and returns its cycles.
  function automatic int predict(input logic [13:0] w, input logic [1:0] pm);
    logic [6:0] a;
    logic [7:0] r, res;
    logic [8:0] t;
    logic cin, wr, sk, zf;
    a = w[6:0];
    r = mem_m[a];
    res = r;
    wr = 1'b1;
    sk = 1'b0;
    zf = 1'b1;
    cin = (w[13:8] == `BRD_OP_ADDC) ? c_m : 1'b0;
    case (w[13:8])
      `BRD_OP_ADD, `BRD_OP_ADDC: begin
        t = {1'b0, acc_m} + {1'b0, r} + {8'h00, cin};
        dc_m = ({1'b0, acc_m[3:0]} + {1'b0, r[3:0]} + {4'h0, cin}) > 5'h0F;
        c_m = t[8];
        res = t[7:0];
      end
      `BRD_OP_AND: res = acc_m & r;
      `BRD_OP_IOR: res = acc_m | r;
      `BRD_OP_COM: res = ~r;
      `BRD_OP_DECSZ, `BRD_OP_INCSZ: begin
        res = w[10] ? r + 8'h01 : r - 8'h01;
        sk = res == 8'h00;
        zf = 1'b0;
      end
      default: begin
        wr = 1'b0;
        zf = 1'b0;
        if (w[13:11] == 3'h3) sk = r[w[9:7]] == w[10];
      end
    endcase
    if (zf) z_m = res == 8'h00;
    if (wr && w[7]) mem_m[a] = res;
    if (wr && !w[7]) acc_m = res;
    return 1 + int'(a < 7'h02 && pm[a[0]]) + int'(sk);
  endfunction : predict

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_cyc(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_cyc

  // Presents a word in phase 0 and counts clocks up to its last fetch.
  task automatic op(input logic [13:0] w, input logic [1:0] pm, input int n);
    int k;
    instr_i = w;
    ptr_pm_i = pm;
    k = 0;
    do begin
      @(posedge mclk_i);
      #1;
      k++;
    end while (fetch_o !== 1'b1 && k < 40);
    ind_s = indirect_o;
    sel_s = ptr_sel_o;
    chk_cyc(k, 4 * n - 1);
    @(posedge mclk_i);
    #1;
  endtask : op

  task automatic arith(input logic [13:0] w, input logic [1:0] pm);
    logic [6:0] a;
    logic [15:0] gt, ex;
    a = w[6:0];
    op(w, pm, predict(w, pm));
    gt = {5'h00, acc_o, carry_o, dcarry_o, zero_o};
    ex = {5'h00, acc_m, c_m, dc_m, z_m};
    chk_val(gt, ex);
    chk_val({8'h00, brd_fregs_i.mem[a]}, {8'h00, mem_m[a]});
    ex = {14'h0000, a < 7'h02, a[0]};
    chk_val({14'h0000, ind_s, sel_s}, ex);
  endtask : arith

  task automatic setm(input logic [6:0] a, input logic [7:0] d);
    mem_m[a] = d;
    brd_fregs_i.mem[a] = d;
  endtask : setm

  // Reset spans three clocks; it clears the expected core state too.
  task automatic do_reset();
    rst_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    {acc_m, c_m, dc_m, z_m} = 11'h000;
  endtask : do_reset

  task automatic test_done();
    if (err_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    for (int i = 0; i < 128; i++) begin
      v = rnd();
      setm(7'(i), v[7:0]);
    end
    do_reset();
    // Flow words leave the accumulator alone; a reset still follows them.
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      op(fw[i] | (v[13:0] & fm[i]), 2'h0, 2);
    end
    do_reset();
    setm(7'h7F, 8'h01);
    arith({`BRD_OP_DECSZ, 1'b1, 7'h7F}, 2'h0);
    setm(7'h10, 8'hFF);
    arith({`BRD_OP_INCSZ, 1'b0, 7'h10}, 2'h0);
    arith({`BRD_OP_ADD, 1'b0, 7'h10}, 2'h0);
    arith({`BRD_OP_ADD, 1'b1, 7'h10}, 2'h0);
    arith({`BRD_OP_ADDC, 1'b0, 7'h00}, 2'h1);
    arith({`BRD_OP_SHL, 1'b0, 7'h10}, 2'h3);
    arith({`BRD_OP_SHRL, 1'b1, 7'h10}, 2'h0);
    arith({`BRD_OP_SHRA, 1'b1, 7'h01}, 2'h2);
    for (int i = 0; i < 300; i++) begin
      v = rnd();
      if (v[15:12] % 9 < 7) begin
        wd = {ops[v[15:12] % 9], v[7:0]};
      end else begin
        wd = {(v[15:12] % 9 == 7) ? `BRD_OP4_BITCLR : `BRD_OP4_BITSET,
          v[9:0]};
      end
      if (v[11:10] == 2'h0) wd[6:1] = 6'h00;
      v = rnd();
      arith(wd, v[1:0]);
    end
    test_done();
  end

  // Watchdog: the run needs well under 200 us.
  initial begin
    #200000;
    err_count++;
    test_done();
  end
endmodule : testbench
